// ==== design/pcs_codec_pkg.sv ====
// constants, code-group values and carrier types for the 4b/5b code-group codec
// assumes a single 100 MHz clock; the nibble rate is a strobe derived from it
package pcs_codec_pkg;

  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          NIBBLE_PERIOD_NS = 40;
  localparam int          NIBBLE_DIV       = NIBBLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  DIV_RESET        = 2'h0;
  localparam logic [1:0]  DIV_LAST         = 2'(NIBBLE_DIV - 1);

  // ==========================================================================
  // control code-groups
  localparam logic [4:0]  CG_IDLE = 5'h1f;
  localparam logic [4:0]  CG_SSD1 = 5'h18;
  localparam logic [4:0]  CG_SSD2 = 5'h11;
  localparam logic [4:0]  CG_ESD1 = 5'h0d;
  localparam logic [4:0]  CG_ESD2 = 5'h07;
  localparam logic [4:0]  CG_HALT = 5'h04;
  localparam logic [4:0]  CG_LPI  = 5'h00;

  // nibbles that control groups stand for
  localparam logic [3:0]  NIB_IDLE = 4'h0;
  localparam logic [3:0]  NIB_SSD  = 4'h5;
  localparam logic [3:0]  NIB_ESD  = 4'h0;
  localparam logic [3:0]  NIB_LPI  = 4'h1;
  localparam logic [3:0]  NIB_ZERO = 4'h0;

  // data nibble 0..f to code-group
  localparam logic [4:0]  DATA_CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  // ==========================================================================
  // scrambler and reset values
  localparam logic [10:0] SCR_SEED      = 11'h7ff;
  localparam logic [4:0]  TX_GROUP_RST  = 5'h1f;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {TX_IDLE, TX_SSD2, TX_DATA, TX_ESD2} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SSD2, RX_DATA} rx_state_t;
  typedef enum logic [3:0] {KIND_DATA, KIND_IDLE, KIND_SSD1, KIND_SSD2, KIND_ESD1, KIND_ESD2,
                            KIND_HALT, KIND_LPI, KIND_INV} cg_kind_t;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mii_tx_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mii_rx_t;

  typedef struct packed {
    cg_kind_t   kind;
    logic [3:0] nib;
  } cg_dec_t;

endpackage

// ==== design/cg_codec.sv ====
// 4b/5b code-group encoder with start/end delimiter injection, optional
// scrambler with bypass, and code-group decoder back to nibbles
// assumes MAC nibbles and receive code-groups are synchronous to clk and
// sampled on the nibble strobe, one group per strobe
`timescale 1ns/1ps

module cg_codec
  import pcs_codec_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // mac transmit side
  input  wire pcs_codec_pkg::mii_tx_t  mii_tx,
  output logic                         nibble_stb,
  // transmit code-group stream
  input  wire logic                    scramble_bypass,
  output logic [4:0]                   tx_group,
  output logic                         tx_group_stb,
  // receive code-group stream and mac receive side
  input  wire logic [4:0]              rx_group,
  output pcs_codec_pkg::mii_rx_t       mii_rx
);
  import pcs_codec_pkg::*;

  // ==========================================================================
  // nibble strobe divider
  logic [1:0]  div_r;
  logic [1:0]  div_nxt;
  wire         tick = (div_r == DIV_LAST);

  assign div_nxt    = tick ? DIV_RESET : div_r + 2'h1;
  assign nibble_stb = tick;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= DIV_RESET;
    else
      div_r <= div_nxt;
  end

  // ==========================================================================
  // transmit state machine
  tx_state_t   tx_st_r;
  tx_state_t   tx_st_nxt;
  logic [4:0]  code_nxt;
  logic [4:0]  code_r;
  wire  [4:0]  data_cg = DATA_CG[mii_tx.d];
  wire         lpi_req = !mii_tx.en && mii_tx.er && (mii_tx.d == NIB_LPI);

  // the first two preamble nibbles are swallowed by the start pair; the mac
  // must hold enable through the whole preamble for the frame to be intact
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    code_nxt  = CG_IDLE;
    case (tx_st_r)
      TX_IDLE:
      begin
        if (mii_tx.en)
        begin
          code_nxt  = CG_SSD1;
          tx_st_nxt = TX_SSD2;
        end
        else if (lpi_req)
          code_nxt = CG_LPI;
      end
      TX_SSD2:
      begin
        code_nxt  = CG_SSD2;
        tx_st_nxt = TX_DATA;
      end
      TX_DATA:
      begin
        if (mii_tx.en)
          code_nxt = mii_tx.er ? CG_HALT : data_cg;
        else
        begin
          code_nxt  = CG_ESD1;
          tx_st_nxt = TX_ESD2;
        end
      end
      TX_ESD2:
      begin
        code_nxt  = CG_ESD2;
        tx_st_nxt = TX_IDLE;
      end
      default:
        tx_st_nxt = TX_IDLE;
    endcase
  end

  // ==========================================================================
  // scrambler, 11-bit lfsr x^11 + x^9 + 1, five bits per group, bit 0 first
  logic [10:0] scr_r;
  logic [15:0] scr_step;
  wire  [4:0]  scr_out  = scr_step[4:0];
  wire  [10:0] scr_nxt  = scr_step[15:5];
  wire  [4:0]  line_nxt = scramble_bypass ? code_nxt : scr_out;

  function automatic logic [15:0] scramble(input logic [10:0] s, input logic [4:0] g);
    logic [10:0] st;
    logic [4:0]  o;
    logic        fb;
    st = s;
    o  = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      fb   = st[10] ^ st[8];
      o[i] = g[i] ^ fb;
      st   = {st[9:0], fb};
    end
    return {st, o};
  endfunction

  assign scr_step = scramble(scr_r, code_nxt);

  // lfsr keeps running while bypassed so a later switch needs no resync
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_r      <= TX_IDLE;
      code_r       <= TX_GROUP_RST;
      tx_group     <= TX_GROUP_RST;
      tx_group_stb <= 1'b0;
      scr_r        <= SCR_SEED;
    end
    else
    begin
      tx_group_stb <= tick;
      if (tick)
      begin
        tx_st_r  <= tx_st_nxt;
        code_r   <= code_nxt;
        tx_group <= line_nxt;
        scr_r    <= scr_nxt;
      end
    end
  end

  // ==========================================================================
  // code-group decoder
  function automatic cg_dec_t decode(input logic [4:0] g);
    cg_dec_t r;
    r.kind = KIND_INV;
    r.nib  = NIB_ZERO;
    for (int i = 0; i < 16; i++)
    begin
      if (DATA_CG[i] == g)
      begin
        r.kind = KIND_DATA;
        r.nib  = 4'(i);
      end
    end
    case (g)
      CG_IDLE: r = '{KIND_IDLE, NIB_IDLE};
      CG_SSD1: r = '{KIND_SSD1, NIB_SSD};
      CG_SSD2: r = '{KIND_SSD2, NIB_SSD};
      CG_ESD1: r = '{KIND_ESD1, NIB_ESD};
      CG_ESD2: r = '{KIND_ESD2, NIB_ESD};
      CG_HALT: r = '{KIND_HALT, NIB_ZERO};
      CG_LPI:  r = '{KIND_LPI, NIB_LPI};
      default: r = r;
    endcase
    return r;
  endfunction

  wire cg_dec_t dec = decode(rx_group);

  // ==========================================================================
  // receive state machine
  rx_state_t   rx_st_r;
  rx_state_t   rx_st_nxt;
  mii_rx_t     rx_nxt;

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_nxt    = '{1'b0, 1'b0, dec.nib};
    case (rx_st_r)
      RX_IDLE:
      begin
        case (dec.kind)
          KIND_IDLE, KIND_ESD2: rx_nxt.d = dec.nib;
          KIND_LPI: rx_nxt.er = 1'b1;
          KIND_SSD1:
          begin
            rx_nxt.dv = 1'b1;
            rx_st_nxt = RX_SSD2;
          end
          default:
          begin
            rx_nxt.er = 1'b1;
            rx_nxt.d  = NIB_ZERO;
          end
        endcase
      end
      RX_SSD2:
      begin
        if (dec.kind == KIND_SSD2)
        begin
          rx_nxt.dv = 1'b1;
          rx_st_nxt = RX_DATA;
        end
        else
        begin
          rx_nxt.er = 1'b1;
          rx_nxt.d  = NIB_ZERO;
          rx_st_nxt = RX_IDLE;
        end
      end
      RX_DATA:
      begin
        if (dec.kind == KIND_DATA)
          rx_nxt.dv = 1'b1;
        else if (dec.kind == KIND_ESD1)
          rx_st_nxt = RX_IDLE;
        else
        begin
          rx_nxt = '{1'b1, 1'b1, NIB_ZERO};
        end
      end
      default:
        rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_r <= RX_IDLE;
      mii_rx  <= '{1'b0, 1'b0, NIB_IDLE};
    end
    else if (tick)
    begin
      rx_st_r <= rx_st_nxt;
      mii_rx  <= rx_nxt;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_STROBE_SPACING: assert property (tick |=> !tick [*3] ##1 tick)
    else $error("nibble strobe not every fourth cycle");

  AST_IDLE_FILL: assert property (tick && tx_st_r == TX_IDLE && !mii_tx.en && !mii_tx.er
                                  |=> code_r == CG_IDLE)
    else $error("idle gap not filled with idle group");

  AST_START_PAIR: assert property (tick && tx_st_r == TX_IDLE && mii_tx.en
                                   |=> code_r == CG_SSD1 ##4 code_r == CG_SSD2)
    else $error("start delimiter pair missing");

  AST_DATA_MAP: assert property (tick && tx_st_r == TX_DATA && mii_tx.en && !mii_tx.er
                                 |=> code_r == DATA_CG[$past(mii_tx.d)])
    else $error("data nibble mapped to wrong group");

  AST_HALT_ON_ERR: assert property (tick && tx_st_r == TX_DATA && mii_tx.en && mii_tx.er
                                    |=> code_r == CG_HALT)
    else $error("transmit error did not give halt");

  AST_END_PAIR: assert property (tick && tx_st_r == TX_DATA && !mii_tx.en
                                 |=> code_r == CG_ESD1 ##4 code_r == CG_ESD2 && tx_st_r == TX_IDLE)
    else $error("end delimiter pair missing");

  AST_LPI_TX: assert property (tick && tx_st_r == TX_IDLE && lpi_req |=> code_r == CG_LPI)
    else $error("low-power idle not encoded");

  AST_BYPASS: assert property (tick && scramble_bypass |=> tx_group == code_r && tx_group_stb)
    else $error("bypass did not pass code-group");

  AST_RX_INVALID: assert property (tick && rx_st_r == RX_DATA && !(dec.kind inside {KIND_DATA, KIND_ESD1})
                                   |=> mii_rx.er && mii_rx.dv && mii_rx.d == NIB_ZERO)
    else $error("invalid group in data not flagged");

  AST_RX_IDLE: assert property (tick && rx_st_r == RX_IDLE && rx_group == CG_IDLE
                                |=> mii_rx.d == NIB_IDLE && !mii_rx.dv && !mii_rx.er)
    else $error("idle group not decoded to quiet zero");

endmodule

// ==== tb/mac_model.sv ====
// mac side model: presents one transmit nibble per strobe from a queue
// assumes the codec takes mii_tx at the rising edge where nibble_stb is high
`timescale 1ns/1ps

module mac_model
  import pcs_codec_pkg::*;
(
  // clock
  input  wire logic              clk,
  // codec strobe and transmit nibbles
  input  wire logic              nibble_stb,
  output pcs_codec_pkg::mii_tx_t mii_tx
);
  // ==========================================================================
  // nibble feed
  mii_tx_t q[$];

  initial mii_tx = '0;

  // an empty queue means enable low, which closes any open frame
  always @(negedge clk)
  begin
    if (nibble_stb === 1'b1)
    begin
      if (q.size() > 0)
        mii_tx <= q.pop_front(); // low-power idle is queued as en=0 er=1 d=0001
      else
        mii_tx <= '0;
    end
  end
endmodule

// ==== tb/tx_4b5b_code_group_codec_tb_top.sv ====
// self-checking bench for the code-group codec
// assumes the mac model feeds transmit nibbles; receive groups come from here
`timescale 1ns/1ps

module tx_4b5b_code_group_codec_tb_top;
  import pcs_codec_pkg::*;
  // ==========================================================================
  // signals
  logic       clk;
  logic       rst_n;
  logic       scramble_bypass;
  logic [4:0] rx_group;
  mii_tx_t    mii_tx;
  logic       nibble_stb;
  logic [4:0] tx_group;
  logic       tx_group_stb;
  mii_rx_t    mii_rx;
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles      = 0;
  // written out here so a slip in the shared table cannot hide itself
  localparam logic [4:0] DATA_EXP [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] BAD_IN_DATA [15] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10,
                                              5'h19, 5'h1f, 5'h18, 5'h11, 5'h07, 5'h00, 5'h04};

  cg_codec DUT (.clk(clk), .rst_n(rst_n), .mii_tx(mii_tx), .nibble_stb(nibble_stb),
                .scramble_bypass(scramble_bypass), .tx_group(tx_group), .tx_group_stb(tx_group_stb),
                .rx_group(rx_group), .mii_rx(mii_rx));
  mac_model mac (.clk(clk), .nibble_stb(nibble_stb), .mii_tx(mii_tx));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // compare and drive helpers
  task automatic chk_group(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t group %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_rx(input mii_rx_t got, input mii_rx_t exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t rx %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got);
    check_count++;
    if (got !== 1'b1)
    begin
      miscompares++;
      $display("BAD t=%0t condition not met", $time);
    end
  endtask

  task automatic next_group(output logic [4:0] g);
    int n;
    n = 0;
    @(negedge clk);
    while (tx_group_stb !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      miscompares++;
      $display("BAD t=%0t no group strobe", $time);
    end
    g = tx_group;
  endtask

  // skips idle fill up to the first group of interest
  task automatic first_non_idle(output logic [4:0] g);
    int n;
    n = 0;
    next_group(g);
    while (g === 5'h1f && n < 12)
    begin
      next_group(g);
      n++;
    end
  endtask

  task automatic rx_step(input logic [4:0] g, input mii_rx_t exp);
    int n;
    n = 0;
    @(negedge clk);
    while (nibble_stb !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 8)
    begin
      miscompares++;
      $display("BAD t=%0t no nibble strobe", $time);
    end
    rx_group = g;
    @(negedge clk);
    chk_rx(mii_rx, exp);
  endtask

  // ==========================================================================
  // scenarios
  task automatic test_reset_idle();
    logic [4:0] g;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      next_group(g);
      chk_group(g, 5'h1f);
    end
    k = 0;
    next_group(g);
    do
    begin
      @(negedge clk);
      k++;
    end
    while (tx_group_stb !== 1'b1 && k < 8);
    chk_flag(k == 4);
    $display("test_reset_idle done");
  endtask

  task automatic test_tx_frame();
    logic [4:0] g;
    for (int i = 0; i < 4; i++)
      mac.q.push_back(6'h25);
    for (int i = 0; i < 16; i++)
      mac.q.push_back({2'b10, 4'(i)});
    mac.q.push_back(6'h33);
    first_non_idle(g);
    chk_group(g, 5'h18);
    next_group(g);
    chk_group(g, 5'h11);
    for (int i = 0; i < 2; i++)
    begin
      next_group(g);
      chk_group(g, 5'h0b);
    end
    for (int i = 0; i < 16; i++)
    begin
      next_group(g);
      chk_group(g, DATA_EXP[i]);
    end
    next_group(g);
    chk_group(g, 5'h04);
    next_group(g);
    chk_group(g, 5'h0d);
    next_group(g);
    chk_group(g, 5'h07);
    for (int i = 0; i < 3; i++)
    begin
      next_group(g);
      chk_group(g, 5'h1f);
    end
    $display("test_tx_frame done");
  endtask

  task automatic test_tx_lpi();
    logic [4:0] g;
    mac.q.push_back(6'h11);
    mac.q.push_back(6'h11);
    first_non_idle(g);
    chk_group(g, 5'h00);
    next_group(g);
    chk_group(g, 5'h00);
    next_group(g);
    chk_group(g, 5'h1f);
    $display("test_tx_lpi done");
  endtask

  // enable back up in the second end slot is ignored; the new frame starts one slot later
  task automatic test_tx_refused();
    logic [4:0] g;
    mii_tx_t    nib [8]   = '{6'h25, 6'h25, 6'h2a, 6'h00, 6'h25, 6'h25, 6'h25, 6'h27};
    logic [4:0] want [10] = '{5'h18, 5'h11, 5'h16, 5'h0d, 5'h07, 5'h18, 5'h11, 5'h0f, 5'h0d, 5'h07};
    foreach (nib[i])
      mac.q.push_back(nib[i]);
    first_non_idle(g);
    chk_group(g, want[0]);
    for (int i = 1; i < 10; i++)
    begin
      next_group(g);
      chk_group(g, want[i]);
    end
    next_group(g);
    chk_group(g, 5'h1f);
    $display("test_tx_refused done");
  endtask

  task automatic test_bypass();
    logic [4:0] g;
    int n;
    n = 0;
    @(negedge clk);
    scramble_bypass = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      next_group(g);
      if (g !== 5'h1f)
        n++;
    end
    chk_flag(n > 0);
    scramble_bypass = 1'b1;
    next_group(g);
    next_group(g);
    chk_group(g, 5'h1f);
    $display("test_bypass done");
  endtask

  task automatic test_rx_frame();
    rx_step(5'h1f, 6'h00);
    rx_step(5'h18, 6'h25);
    rx_step(5'h11, 6'h25);
    for (int i = 0; i < 16; i++)
      rx_step(DATA_EXP[i], {2'b10, 4'(i)});
    for (int i = 0; i < 15; i++)
      rx_step(BAD_IN_DATA[i], 6'h30);
    rx_step(5'h0d, 6'h00);
    rx_step(5'h07, 6'h00);
    rx_step(5'h00, 6'h11);
    rx_step(5'h19, 6'h10);
    rx_step(5'h18, 6'h25);
    rx_step(5'h1e, 6'h10);
    rx_step(5'h1f, 6'h00);
    $display("test_rx_frame done");
  endtask

  // ==========================================================================
  // run
  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    scramble_bypass = 1'b1;
    rx_group = 5'h1f;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    test_reset_idle();
    test_tx_frame();
    test_tx_lpi();
    test_tx_refused();
    test_bypass();
    test_rx_frame();
    conclude();
  end
endmodule
